// file: hdl/lbs_pkg.sv
// Behaviour
// [R1] Strobe held low for whole transfer
// [R2] Strobe driven only while bus owner
// [R3] Strobe asserted after local clock fall
// [R4] Address group driven from prior rise
// [R5] Strobe driven high before release
// [R6] Slave samples strobe on falling edge
// [R7] Claim only with a select low
// [R8] External master gives valid address group
// [R9] Request, grant, ownership three-wire handshake
// [R10] Ownership asserted from a falling edge
// [R11] Ownership input sampled twice before use
// [R12] Register offset from low twelve bits
package lbs_pkg;

  localparam int ADDR_W = 32;
  localparam int TC_W   = 4;
  localparam int SIZE_W = 2;
  localparam int OFS_W  = 12;

  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [TC_W-1:0]   TC_RST   = 4'h0;
  localparam logic [SIZE_W-1:0] SIZE_RST = 2'h0;
  localparam logic [OFS_W-1:0]  OFS_RST  = 12'h000;

  // Passes of the ownership double sampler
  localparam int OWN_SAMPLES = 2;

  typedef enum logic [2:0] {
    LBS_IDLE = 3'b000,
    LBS_REQ  = 3'b001,
    LBS_OWN  = 3'b010,
    LBS_ADDR = 3'b011,
    LBS_STRB = 3'b100,
    LBS_NEG  = 3'b101,
    LBS_REL  = 3'b110
  } lbs_state_t;

endpackage

// file: hdl/lbs_dsamp.sv
`timescale 1ns/1ps
// Two-stage sampler advanced only on enable; output is the second stage
module lbs_dsamp #(
  parameter int        W   = 1,
  parameter logic      RST = 1'b1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;

  always_comb begin
    next_stage1 = stage1;
    next_stage2 = stage2;
    if (en_i) begin
      next_stage1 = d_i;
      next_stage2 = stage1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stage1 <= {W{RST}};
      stage2 <= {W{RST}};
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign q_o = stage2;

endmodule

// file: hdl/lbs_port.sv
`timescale 1ns/1ps
module lbs_port (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  input  wire logic                        local_bus_clock_i,
  // Master user side
  input  wire logic                        mst_req_i,
  input  wire logic [lbs_pkg::ADDR_W-1:0]  mst_addr_i,
  input  wire logic [lbs_pkg::TC_W-1:0]    mst_tc_i,
  input  wire logic [lbs_pkg::SIZE_W-1:0]  mst_size_i,
  input  wire logic                        mst_read_i,
  input  wire logic                        mst_end_i,
  output logic                             mst_busy_o,
  output logic                             mst_strobe_o,
  // Arbitration pins
  output logic                             bus_request_n_o,
  input  wire logic                        bus_grant_n_i,
  input  wire logic                        bus_owned_n_i,
  output logic                             bus_owned_n_o,
  output logic                             bus_owned_oe_n_o,
  // Strobe pin
  input  wire logic                        addr_strobe_n_i,
  output logic                             addr_strobe_n_o,
  output logic                             addr_strobe_oe_n_o,
  // Address group pins
  input  wire logic [lbs_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [lbs_pkg::TC_W-1:0]    transfer_code_i,
  input  wire logic [lbs_pkg::SIZE_W-1:0]  transfer_size_i,
  input  wire logic                        read_write_i,
  output logic      [lbs_pkg::ADDR_W-1:0]  addr_o,
  output logic      [lbs_pkg::TC_W-1:0]    transfer_code_o,
  output logic      [lbs_pkg::SIZE_W-1:0]  transfer_size_o,
  output logic                             read_write_o,
  output logic                             addr_grp_oe_n_o,
  // Chip selects
  input  wire logic                        reg_select_n_i,
  input  wire logic                        bridge_select_n_i,
  // Slave user side
  output logic                             slv_hit_o,
  output logic                             slv_is_reg_o,
  output logic      [lbs_pkg::OFS_W-1:0]   slv_offset_o,
  output logic      [lbs_pkg::ADDR_W-1:0]  slv_addr_o,
  output logic      [lbs_pkg::TC_W-1:0]    slv_tc_o,
  output logic      [lbs_pkg::SIZE_W-1:0]  slv_size_o,
  output logic                             slv_read_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Local bus clock edge detection

  logic lclk_q;
  logic next_lclk_q;
  logic fall_ev;
  logic rise_ev;

  always_comb begin
    next_lclk_q = ce_i ? local_bus_clock_i : lclk_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lclk_q <= 1'b0;
    end else begin
      lclk_q <= next_lclk_q;
    end
  end

  assign fall_ev = ce_i & lclk_q & ~local_bus_clock_i;
  assign rise_ev = ce_i & ~lclk_q & local_bus_clock_i;

  ////////////////////////////////////////////////////////////////////////////
  // Ownership input, double sampled on falling edges

  logic own_free;
  logic own_seen;

  lbs_dsamp #(
    .W   (1),
    .RST (1'b1)
  ) u_own_samp (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .en_i      (fall_ev),
    .d_i       (bus_owned_n_i),
    .q_o       (own_seen)
  ); // [R11]

  // Filtered level lags our own release drive; present sample must agree
  assign own_free = own_seen & bus_owned_n_i; // [R11]

  ////////////////////////////////////////////////////////////////////////////
  // Master sequencer

  lbs_pkg::lbs_state_t state;
  lbs_pkg::lbs_state_t next_state;
  logic [lbs_pkg::ADDR_W-1:0] m_addr;
  logic [lbs_pkg::TC_W-1:0]   m_tc;
  logic [lbs_pkg::SIZE_W-1:0] m_size;
  logic                       m_read;
  logic [lbs_pkg::ADDR_W-1:0] next_m_addr;
  logic [lbs_pkg::TC_W-1:0]   next_m_tc;
  logic [lbs_pkg::SIZE_W-1:0] next_m_size;
  logic                       next_m_read;

  always_comb begin
    next_state  = state;
    next_m_addr = m_addr;
    next_m_tc   = m_tc;
    next_m_size = m_size;
    next_m_read = m_read;
    case (state)
      lbs_pkg::LBS_IDLE: begin
        if (ce_i && mst_req_i) begin
          next_state = lbs_pkg::LBS_REQ;
        end
      end
      lbs_pkg::LBS_REQ: begin
        // Take the bus once granted and nobody else holds it
        if (fall_ev && !bus_grant_n_i && own_free) begin // [R9] [R10]
          next_state = lbs_pkg::LBS_OWN;
        end
      end
      lbs_pkg::LBS_OWN: begin
        if (rise_ev) begin // [R4]
          next_state  = lbs_pkg::LBS_ADDR;
          next_m_addr = mst_addr_i;
          next_m_tc   = mst_tc_i;
          next_m_size = mst_size_i;
          next_m_read = mst_read_i;
        end
      end
      lbs_pkg::LBS_ADDR: begin
        if (fall_ev) begin // [R3]
          next_state = lbs_pkg::LBS_STRB;
        end
      end
      lbs_pkg::LBS_STRB: begin
        if (rise_ev && mst_end_i) begin // [R1]
          next_state = lbs_pkg::LBS_NEG;
        end
      end
      lbs_pkg::LBS_NEG: begin
        if (fall_ev) begin // [R5]
          next_state = lbs_pkg::LBS_REL;
        end
      end
      lbs_pkg::LBS_REL: begin
        if (fall_ev) begin
          next_state = lbs_pkg::LBS_IDLE;
        end
      end
      default: begin
        next_state = lbs_pkg::LBS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state  <= lbs_pkg::LBS_IDLE;
      m_addr <= lbs_pkg::ADDR_RST;
      m_tc   <= lbs_pkg::TC_RST;
      m_size <= lbs_pkg::SIZE_RST;
      m_read <= 1'b1;
    end else begin
      state  <= next_state;
      m_addr <= next_m_addr;
      m_tc   <= next_m_tc;
      m_size <= next_m_size;
      m_read <= next_m_read;
    end
  end

  logic is_owner;
  logic strobe_drv;
  logic grp_drv;

  assign is_owner   = (state == lbs_pkg::LBS_OWN)  ||
                      (state == lbs_pkg::LBS_ADDR) ||
                      (state == lbs_pkg::LBS_STRB) ||
                      (state == lbs_pkg::LBS_NEG)  ||
                      (state == lbs_pkg::LBS_REL);
  assign strobe_drv = (state == lbs_pkg::LBS_STRB) ||
                      (state == lbs_pkg::LBS_NEG);
  assign grp_drv    = (state == lbs_pkg::LBS_ADDR) || strobe_drv;

  assign bus_request_n_o    = ~(state == lbs_pkg::LBS_REQ); // [R9]
  assign bus_owned_oe_n_o   = ~is_owner; // [R10]
  // Ownership rescinded high for one local clock before release
  assign bus_owned_n_o      = (state == lbs_pkg::LBS_REL);
  assign addr_strobe_oe_n_o = ~strobe_drv; // [R2]
  assign addr_strobe_n_o    = ~(state == lbs_pkg::LBS_STRB); // [R1] [R5]
  assign addr_grp_oe_n_o    = ~grp_drv; // [R4]
  assign addr_o             = m_addr;
  assign transfer_code_o    = m_tc;
  assign transfer_size_o    = m_size;
  assign read_write_o       = m_read;
  assign mst_busy_o         = (state != lbs_pkg::LBS_IDLE);
  assign mst_strobe_o       = (state == lbs_pkg::LBS_STRB);

  ////////////////////////////////////////////////////////////////////////////
  // Slave claim on falling edges

  logic                       as_prev;
  logic                       hit;
  logic                       is_reg;
  logic [lbs_pkg::OFS_W-1:0]  s_ofs;
  logic [lbs_pkg::ADDR_W-1:0] s_addr;
  logic [lbs_pkg::TC_W-1:0]   s_tc;
  logic [lbs_pkg::SIZE_W-1:0] s_size;
  logic                       s_read;
  logic                       next_as_prev;
  logic                       next_hit;
  logic                       next_is_reg;
  logic [lbs_pkg::OFS_W-1:0]  next_s_ofs;
  logic [lbs_pkg::ADDR_W-1:0] next_s_addr;
  logic [lbs_pkg::TC_W-1:0]   next_s_tc;
  logic [lbs_pkg::SIZE_W-1:0] next_s_size;
  logic                       next_s_read;
  logic                       claim;

  // Claim only at a fresh strobe, with a select, while not master
  assign claim = !addr_strobe_n_i && as_prev && !is_owner &&
                 (!reg_select_n_i || !bridge_select_n_i); // [R7] [R8]

  always_comb begin
    next_as_prev = as_prev;
    next_hit     = ce_i ? 1'b0 : hit;
    next_is_reg  = is_reg;
    next_s_ofs   = s_ofs;
    next_s_addr  = s_addr;
    next_s_tc    = s_tc;
    next_s_size  = s_size;
    next_s_read  = s_read;
    if (fall_ev) begin // [R6]
      next_as_prev = addr_strobe_n_i;
      if (claim) begin
        next_hit    = 1'b1;
        next_is_reg = !reg_select_n_i;
        next_s_ofs  = addr_i[lbs_pkg::OFS_W-1:0]; // [R12]
        next_s_addr = addr_i;
        next_s_tc   = transfer_code_i;
        next_s_size = transfer_size_i;
        next_s_read = read_write_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      as_prev <= 1'b1;
      hit     <= 1'b0;
      is_reg  <= 1'b0;
      s_ofs   <= lbs_pkg::OFS_RST;
      s_addr  <= lbs_pkg::ADDR_RST;
      s_tc    <= lbs_pkg::TC_RST;
      s_size  <= lbs_pkg::SIZE_RST;
      s_read  <= 1'b1;
    end else begin
      as_prev <= next_as_prev;
      hit     <= next_hit;
      is_reg  <= next_is_reg;
      s_ofs   <= next_s_ofs;
      s_addr  <= next_s_addr;
      s_tc    <= next_s_tc;
      s_size  <= next_s_size;
      s_read  <= next_s_read;
    end
  end

  assign slv_hit_o    = hit;
  assign slv_is_reg_o = is_reg;
  assign slv_offset_o = s_ofs;
  assign slv_addr_o   = s_addr;
  assign slv_tc_o     = s_tc;
  assign slv_size_o   = s_size;
  assign slv_read_o   = s_read;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  strobe_owner_a: assert property (@(posedge sys_clk_i) // [R2]
    disable iff (rst_i)
    !addr_strobe_oe_n_o |-> !bus_owned_oe_n_o && !bus_owned_n_o)
    else $error("Strobe driven without ownership");

  strobe_hold_a: assert property (@(posedge sys_clk_i) // [R1]
    disable iff (rst_i)
    (state == lbs_pkg::LBS_STRB) && !(rise_ev && mst_end_i)
      |=> !addr_strobe_n_o && !addr_strobe_oe_n_o)
    else $error("Strobe dropped mid transfer");

  strobe_fall_a: assert property (@(posedge sys_clk_i) // [R3]
    disable iff (rst_i)
    $fell(addr_strobe_n_o) |-> $past(fall_ev))
    else $error("Strobe asserted off a falling edge");

  group_setup_a: assert property (@(posedge sys_clk_i) // [R4]
    disable iff (rst_i)
    $fell(addr_strobe_n_o) |-> $past(!addr_grp_oe_n_o) && $stable(addr_o))
    else $error("Address group not set up before strobe");

  strobe_rescind_a: assert property (@(posedge sys_clk_i) // [R5]
    disable iff (rst_i)
    $rose(addr_strobe_oe_n_o) |-> $past(addr_strobe_n_o))
    else $error("Strobe released while low");

  slave_edge_a: assert property (@(posedge sys_clk_i) // [R6]
    disable iff (rst_i)
    ce_i && $past(ce_i) && slv_hit_o |-> $past(fall_ev))
    else $error("Slave claim off a falling edge");

  slave_select_a: assert property (@(posedge sys_clk_i) // [R7]
    disable iff (rst_i)
    ce_i && $past(ce_i) && slv_hit_o |-> $past(!addr_strobe_n_i &&
                        (!reg_select_n_i || !bridge_select_n_i)))
    else $error("Slave claim without strobe and select");

  own_edge_a: assert property (@(posedge sys_clk_i) // [R10]
    disable iff (rst_i)
    $fell(bus_owned_oe_n_o) |-> $past(fall_ev) && !bus_owned_n_o)
    else $error("Ownership taken off a falling edge");

  own_double_a: assert property (@(posedge sys_clk_i) // [R11]
    disable iff (rst_i)
    $fell(bus_owned_oe_n_o) |-> $past(own_free) && $past(!bus_grant_n_i))
    else $error("Ownership taken without sampled free bus");

  slave_offset_a: assert property (@(posedge sys_clk_i) // [R12]
    disable iff (rst_i)
    ce_i && $past(ce_i) && slv_hit_o
      |-> slv_offset_o == $past(addr_i[lbs_pkg::OFS_W-1:0]))
    else $error("Slave offset not low twelve address bits");

endmodule

// file: tb/lbs_host_model.sv
`timescale 1ns/1ps
// Far-side master: makes the local clock, grants, owns and runs cycles
module lbs_host_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        bus_request_n_i,
  output logic             local_bus_clock_o,
  output logic             bus_grant_n_o,
  output logic             own_n_o,
  output logic             strobe_n_o,
  output logic             reg_select_n_o,
  output logic             bridge_select_n_o,
  output logic [31:0]      addr_o
);
  logic [1:0] div;

  initial begin
    div = 2'h0;
    local_bus_clock_o = 1'b0;
    bus_grant_n_o = 1'b1;
    own_n_o = 1'b1;
    strobe_n_o = 1'b1;
    reg_select_n_o = 1'b1;
    bridge_select_n_o = 1'b1;
    addr_o = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Free running local clock, eight system cycles a period
  always @(posedge sys_clk_i) begin
    div <= rst_i ? 2'h0 : div + 2'h1;
    if (!rst_i && div == 2'h3) begin
      local_bus_clock_o <= #1 ~local_bus_clock_o;
    end
  end

  // Grant follows request even while another owner still holds on
  always @(posedge sys_clk_i) begin
    bus_grant_n_o <= #1 bus_request_n_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic set_own(input bit v);
    own_n_o = ~v;
  endtask

  // Strobe held across two falling edges; address valid with it
  task automatic ext_cycle(input logic [31:0] a, input bit rs, input bit bs);
    @(posedge local_bus_clock_o);
    @(posedge sys_clk_i);
    #1;
    addr_o = a;
    own_n_o = 1'b0;
    reg_select_n_o = ~rs;
    bridge_select_n_o = ~bs;
    strobe_n_o = 1'b0;
    repeat (2) @(negedge local_bus_clock_o);
    @(posedge sys_clk_i);
    #1;
    strobe_n_o = 1'b1;
    reg_select_n_o = 1'b1;
    bridge_select_n_o = 1'b1;
    own_n_o = 1'b1;
    addr_o = ~a;
  endtask
endmodule

// file: tb/lbs_port_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module lbs_port_tb;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        mst_req = 1'b0, mst_end = 1'b0, mst_read = 1'b0;
  logic [31:0] mst_addr = 32'h0;
  logic [3:0]  mst_tc = 4'h0;
  logic [1:0]  mst_size = 2'h0;
  logic        lbclk, grant_n, host_own_n, host_strobe_n, rsel_n, bsel_n;
  logic [31:0] host_addr, addr_w, addr_o;
  logic        strobe_w, owned_w, prev_strobe = 1'b1, prev_grp_oe_n = 1'b1;
  logic        busy, req_n, own_o, own_oe_n, stb_o, stb_oe_n, grp_oe_n, rw_o;
  logic        hit, is_reg, slv_read, mst_stb, ce = 1'b1;
  logic [3:0]  tc_o, slv_tc;
  logic [1:0]  size_o, slv_size;
  logic [11:0] ofs;
  logic [31:0] slv_addr;
  int          errors = 0, total_checks = 0, hits = 0;

  initial forever #10 sys_clk_i = ~sys_clk_i;

  assign strobe_w = stb_oe_n ? host_strobe_n : stb_o;
  assign owned_w  = own_oe_n ? host_own_n : own_o;
  assign addr_w   = grp_oe_n ? host_addr : addr_o;

  lbs_port lbs_port_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce),
    .local_bus_clock_i(lbclk), .mst_req_i(mst_req), .mst_addr_i(mst_addr),
    .mst_tc_i(mst_tc), .mst_size_i(mst_size), .mst_read_i(mst_read),
    .mst_end_i(mst_end), .mst_busy_o(busy), .mst_strobe_o(mst_stb),
    .bus_request_n_o(req_n), .bus_grant_n_i(grant_n),
    .bus_owned_n_i(owned_w), .bus_owned_n_o(own_o),
    .bus_owned_oe_n_o(own_oe_n), .addr_strobe_n_i(strobe_w),
    .addr_strobe_n_o(stb_o), .addr_strobe_oe_n_o(stb_oe_n),
    .addr_i(addr_w), .transfer_code_i(grp_oe_n ? 4'h5 : tc_o),
    .transfer_size_i(grp_oe_n ? 2'h1 : size_o),
    .read_write_i(grp_oe_n ? 1'b1 : rw_o), .addr_o(addr_o),
    .transfer_code_o(tc_o), .transfer_size_o(size_o), .read_write_o(rw_o),
    .addr_grp_oe_n_o(grp_oe_n), .reg_select_n_i(rsel_n),
    .bridge_select_n_i(bsel_n), .slv_hit_o(hit), .slv_is_reg_o(is_reg),
    .slv_offset_o(ofs), .slv_addr_o(slv_addr), .slv_tc_o(slv_tc),
    .slv_size_o(slv_size), .slv_read_o(slv_read));

  lbs_host_model lbs_host_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .bus_request_n_i(req_n), .local_bus_clock_o(lbclk),
    .bus_grant_n_o(grant_n), .own_n_o(host_own_n),
    .strobe_n_o(host_strobe_n), .reg_select_n_o(rsel_n),
    .bridge_select_n_o(bsel_n), .addr_o(host_addr));

  ////////////////////////////////////////////////////////////////////////
  // Watch strobe onset and ownership while the strobe is driven
  always @(posedge sys_clk_i) begin
    if (!rst_i && strobe_w === 1'b0 && prev_strobe === 1'b1 && !stb_oe_n) begin
      `CHK(lbclk, 1'b0)
      `CHK(prev_grp_oe_n, 1'b0)
    end
    if (!rst_i && stb_oe_n === 1'b0) `CHK(own_oe_n, 1'b0)
    if (hit === 1'b1) hits++;
    prev_strobe <= strobe_w;
    prev_grp_oe_n <= grp_oe_n;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic run_slave(input logic [31:0] a, input bit rs, input bit bs,
                           input int exp);
    int h0;
    h0 = hits;
    lbs_host_model_inst.ext_cycle(a, rs, bs);
    tick(10);
    `CHK(hits - h0, exp)
    if (exp == 1) begin
      `CHK(ofs, a[11:0])
      `CHK(is_reg, logic'(rs))
      `CHK(slv_addr, a)
      `CHK(slv_tc, 4'h5)
      `CHK(slv_size, 2'h1)
      `CHK(slv_read, 1'b1)
    end
  endtask

  task automatic run_master(input logic [31:0] a, input bit contend);
    int n;
    lbs_host_model_inst.set_own(contend);
    mst_addr = a;
    mst_tc = 4'ha;
    mst_size = 2'h2;
    mst_req = 1'b1;
    tick(1);
    mst_req = 1'b0;
    if (contend) begin
      tick(40);
      `CHK(stb_oe_n, 1'b1)
      `CHK(own_oe_n, 1'b1)
      lbs_host_model_inst.set_own(1'b0);
    end
    n = 0;
    while (strobe_w !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    `CHK(strobe_w, 1'b0)
    `CHK(addr_w, a)
    `CHK(tc_o, 4'ha)
    `CHK(size_o, 2'h2)
    `CHK(rw_o, 1'b0)
    `CHK(owned_w, 1'b0)
    tick(20);
    `CHK(strobe_w, 1'b0)
    `CHK(mst_stb, 1'b1)
    ce = 1'b0;
    mst_end = 1'b1;
    tick(24);
    `CHK(strobe_w, 1'b0)
    ce = 1'b1;
    n = 0;
    while (stb_o !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    mst_end = 1'b0;
    `CHK(stb_oe_n, 1'b0)
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    `CHK(stb_oe_n, 1'b1)
    `CHK(own_oe_n, 1'b1)
  endtask

  initial begin
    #400000;
    errors++;
    results();
  end

  initial begin
    tick(3);
    rst_i = 1'b0;
    run_slave(32'h1234_5abc, 1'b1, 1'b0, 1);
    run_slave(32'h8000_0fff, 1'b0, 1'b1, 1);
    run_slave(32'h0000_0123, 1'b0, 1'b0, 0);
    run_master(32'hdead_0004, 1'b0);
    run_master(32'h0000_0ff8, 1'b1);
    run_slave(32'h0400_0010, 1'b1, 1'b1, 1);
    results();
  end
endmodule
